// *** include/iqs_pkg.sv ***
`default_nettype none
package iqs_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] IQS_OFF_QINDEX = 8'hE0;  // queue select and commit
   localparam logic [7:0] IQS_OFF_PRIO   = 8'hEC;  // staging priority mask
   localparam logic [7:0] IQS_OFF_STATUS = 8'hF0;  // status / acknowledge
   localparam logic [7:0] IQS_OFF_GLOBAL_INT_MASK_REG  = 8'hF4;  // global mask
   localparam logic [7:0] IQS_OFF_CTRL   = 8'hF8;  // direction control
   // status field positions
   localparam int IQS_BIT_OVF   = 31;
   localparam int IQS_BIT_LOCAL = 17;
   localparam int IQS_BIT_FIFO  = 16;
   localparam int IQS_NQ        = 9;   // queues 8..0
   localparam int IQS_HPQ       = 7;   // hardwired high-priority queue
   localparam int IQS_NCHQ      = 8;   // channel queues 0..7
   // queue index register fields
   localparam int IQS_BIT_COMMIT = 18;
   localparam int IQS_QSEL_W     = 4;
   // reset values
   localparam logic [31:0] IQS_GLOBAL_INT_MASK_REG_RST  = 32'hFFFF_FFFF;
   localparam logic [31:0] IQS_PRIO_RST   = 32'h0000_0000;
   localparam logic [31:0] IQS_STATUS_IMP = 32'h8003_01FF;  // implemented bits
   localparam logic [31:0] IQS_ZERO       = 32'h0000_0000;
endpackage
`default_nettype wire

// *** rtl/iqs_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
// registers the local pin level and flags its activating edge
module iqs_edge (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic level,
   output logic      rise
);
   typedef struct packed {
      logic prev;
   } iqs_edge_s;
   iqs_edge_s st, next_st;
   always_comb begin
      next_st = st;
      next_st.prev = level;
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) st <= '0;
      else st <= next_st;
   end
   assign rise = level & ~st.prev;
endmodule
`default_nettype wire

// *** rtl/iqs_router.sv ***
`timescale 1ns/100ps
`default_nettype none
// routes one channel vector to its own queue or to the high-priority queue
module iqs_router #(
   parameter int VW = 32
) (
   input  wire logic [VW-1:0] vec,
   input  wire logic [2:0]    chan_q,
   input  wire logic [VW-1:0] pmask,
   output logic      [3:0]    dest_q
);
   import iqs_pkg::*;
   // any covered bit forwards; otherwise regular queue (mixed vectors go high)
   always_comb begin
      if ((vec & pmask) != '0 && chan_q != 3'(IQS_HPQ)) begin
         dest_q = 4'(IQS_HPQ);
      end else begin
         dest_q = {1'b0, chan_q};
      end
   end
endmodule
`default_nettype wire

// *** rtl/iqs_top.sv ***
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - channel vector goes to its queue 0-7
// - queue 7 is hardwired high-priority queue
// - stage mask, select queue, commit copies it
// - covered bit forwards vector to queue 7
// - uncovered-only vectors stay in regular queue
// - unmasked status bits drive host interrupt
// - overflow bit 31 sticky, write-one clears
// - local pin activation asserts host interrupt in input mode
// - bit 17 follows local pin in input mode, ignores writes
// - bit 16 fifo nonempty in both modes, interrupts in input mode only
// - queue bits 8-0 set on write, w1c
// - global mask resets to all ones
// - local mask bit 0 forwards, 1 blocks
// - fifo and overflow masks gate likewise
// - queue mask gates pin, not vectors
// - mask commit to queue 7 ignored
// - direction 0 output, 1 input
module iqs_top #(
   parameter int VW = 32
) (
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [31:0]   reg_rdata,
   input  wire logic          vec_valid,
   input  wire logic [VW-1:0] vec_data,
   input  wire logic [2:0]    vec_chan,
   input  wire logic          cmd_vec_valid,
   input  wire logic          vec_lost,
   input  wire logic          fifo_nonempty,
   input  wire logic          local_int_n_in,
   output logic               local_int_dir_in,
   output logic               route_valid,
   output logic      [3:0]    route_queue,
   output logic      [VW-1:0] route_data,
   output logic               host_int_n
);
   import iqs_pkg::*;

   // state of the block, except the pin edge register kept in u_edge
   typedef struct packed {
      logic [31:0]             prio;
      logic [31:0]             global_int_mask_reg;
      logic [IQS_QSEL_W-1:0]   qsel;
      logic                    dir;
      logic                    ovf;
      logic [IQS_NQ-1:0]       qflag;
      logic [IQS_NCHQ-2:0][VW-1:0] qmask;  // masks of queues 0..6
      logic [31:0]             rdata;
      logic                    rvalid;
      logic [3:0]              rq;
      logic [VW-1:0]           rdat;
   } iqs_s;

   iqs_s st, next_st;
   logic [3:0]  dest_q;       // router answer
   logic        local_rise;   // activating edge of local pin
   logic        local_act;    // local pin asserted (active low)
   logic [31:0] status;       // assembled status word
   logic [31:0] pending;      // unmasked status bits
   logic        wr_stat;

   // write-one-clear decode, used for several flag groups
   function automatic logic w1c(input logic wr, input logic bitv);
      return wr & bitv;
   endfunction

   // mask of the vector's own channel; queue 7 has none
   logic [VW-1:0] cur_mask;
   always_comb begin
      cur_mask = '0;
      if (vec_chan != 3'(IQS_HPQ)) cur_mask = st.qmask[vec_chan];
   end

   iqs_router #(.VW(VW)) u_router (
      .vec    (vec_data),
      .chan_q (vec_chan),
      .pmask  (cur_mask),
      .dest_q (dest_q)
   );

   assign local_act = ~local_int_n_in;

   iqs_edge u_edge (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .level   (local_act),
      .rise    (local_rise)
   );

   // status word: reserved bits stay zero
   always_comb begin
      status = IQS_ZERO;
      status[IQS_BIT_OVF] = st.ovf;
      status[IQS_BIT_LOCAL] = st.dir & local_act;
      status[IQS_BIT_FIFO] = fifo_nonempty;
      status[IQS_NQ-1:0] = st.qflag;
   end

   // mask gates only the pin; flags still set
   always_comb begin
      pending = status & ~st.global_int_mask_reg & IQS_STATUS_IMP;
      pending[IQS_BIT_FIFO] = status[IQS_BIT_FIFO] & st.dir & ~st.global_int_mask_reg[IQS_BIT_FIFO];
   end

   // edge asserts the pin at once, level keeps it
   assign host_int_n = ~((|pending) |
      (local_rise & st.dir & ~st.global_int_mask_reg[IQS_BIT_LOCAL]));

   assign wr_stat = reg_wr && reg_addr == IQS_OFF_STATUS;

   // next state
   always_comb begin
      next_st = st;
      next_st.rvalid = vec_valid;
      if (vec_valid) begin
         next_st.rq = dest_q;
         next_st.rdat = vec_data;
      end
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            IQS_OFF_PRIO: next_st.prio = reg_wdata;
            IQS_OFF_GLOBAL_INT_MASK_REG: next_st.global_int_mask_reg = reg_wdata;
            IQS_OFF_CTRL: next_st.dir = reg_wdata[0];
            IQS_OFF_QINDEX: begin
               next_st.qsel = reg_wdata[IQS_QSEL_W-1:0];
               // commit staged mask; queue 7 and 8 ignored
               if (reg_wdata[IQS_BIT_COMMIT] &&
                   reg_wdata[IQS_QSEL_W-1:0] < 4'(IQS_HPQ)) begin
                  next_st.qmask[reg_wdata[2:0]] = st.prio[VW-1:0];
               end
            end
            default: ;
         endcase
      end
      // clears first, sets after so that an event wins
      for (int i = 0; i < IQS_NQ; i++) begin
         if (w1c(wr_stat, reg_wdata[i])) next_st.qflag[i] = 1'b0;
      end
      if (w1c(wr_stat, reg_wdata[IQS_BIT_OVF])) next_st.ovf = 1'b0;
      if (vec_valid) next_st.qflag[dest_q] = 1'b1;
      if (cmd_vec_valid) next_st.qflag[IQS_NQ-1] = 1'b1;
      if (vec_lost) next_st.ovf = 1'b1;
      // read data, one cycle later
      next_st.rdata = IQS_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            IQS_OFF_PRIO: next_st.rdata = st.prio;
            IQS_OFF_STATUS: next_st.rdata = status;
            IQS_OFF_GLOBAL_INT_MASK_REG: next_st.rdata = st.global_int_mask_reg;
            IQS_OFF_CTRL: next_st.rdata = {31'h0, st.dir};
            IQS_OFF_QINDEX: next_st.rdata = {28'h0, st.qsel};
            default: next_st.rdata = IQS_ZERO;
         endcase
      end
   end

   // register the state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st <= '0;
         st.global_int_mask_reg <= IQS_GLOBAL_INT_MASK_REG_RST;
         st.prio <= IQS_PRIO_RST;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign route_valid = st.rvalid;
   assign route_queue = st.rq;
   assign route_data = st.rdat;
   assign local_int_dir_in = st.dir;

   // checks
   AST_MASK_RESET: assert property (@(posedge mclk)
      $fell(sys_rst) |-> st.global_int_mask_reg == IQS_GLOBAL_INT_MASK_REG_RST) else $error("mask reset");
   AST_HP_ROUTE: assert property (@(posedge mclk) disable iff (sys_rst)
      vec_valid && (vec_data & cur_mask) != '0 |=> route_queue == 4'(IQS_HPQ))
      else $error("hp route");
   AST_REG_ROUTE: assert property (@(posedge mclk) disable iff (sys_rst)
      vec_valid && (vec_data & cur_mask) == '0 |=> route_queue == {1'b0, $past(vec_chan)})
      else $error("regular route");
   AST_OVF_STICK: assert property (@(posedge mclk) disable iff (sys_rst)
      st.ovf && !(wr_stat && reg_wdata[IQS_BIT_OVF]) |=> st.ovf) else $error("ovf");
   AST_QFLAG_SET: assert property (@(posedge mclk) disable iff (sys_rst)
      vec_valid |=> st.qflag[route_queue]) else $error("qflag");
   AST_PIN: assert property (@(posedge mclk) disable iff (sys_rst)
      (|pending) |-> !host_int_n) else $error("pin");
   AST_MASKED_QUIET: assert property (@(posedge mclk) disable iff (sys_rst)
      st.global_int_mask_reg == IQS_GLOBAL_INT_MASK_REG_RST |-> host_int_n) else $error("masked");
   AST_COMMIT: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == IQS_OFF_QINDEX && reg_wdata[IQS_BIT_COMMIT]
      && reg_wdata[3:0] < 4'(IQS_HPQ)
      |=> st.qmask[$past(reg_wdata[2:0])] == $past(st.prio[VW-1:0])) else $error("commit");
   AST_LOCAL_RO: assert property (@(posedge mclk) disable iff (sys_rst)
      status[IQS_BIT_LOCAL] |-> st.dir && !local_int_n_in) else $error("local");
   COV_HP: cover property (@(posedge mclk) route_valid && route_queue == 4'(IQS_HPQ));
   COV_INT: cover property (@(posedge mclk) !host_int_n);
   COV_OVF: cover property (@(posedge mclk) st.ovf);
   COV_LOCAL_EDGE: cover property (@(posedge mclk) local_rise && st.dir);
   COV_COMMIT: cover property (@(posedge mclk)
      reg_wr && reg_addr == IQS_OFF_QINDEX && reg_wdata[IQS_BIT_COMMIT]);

   // pin side: the edge cycle and the level cycles are watched apart,
   // although status bit 17 is not registered and follows the pin at once,
   // so it pulls the pin low in the edge cycle together with the edge term
   AST_LOCAL_EDGE: assert property (@(posedge mclk) disable iff (sys_rst)
      local_rise && st.dir && !st.global_int_mask_reg[IQS_BIT_LOCAL] |-> !host_int_n)
      else $error("local edge");
   AST_FIFO_GATE: assert property (@(posedge mclk) disable iff (sys_rst)
      fifo_nonempty && st.dir && !st.global_int_mask_reg[IQS_BIT_FIFO] |-> !host_int_n)
      else $error("fifo gate");
   AST_LOCAL_BLOCK: assert property (@(posedge mclk) disable iff (sys_rst)
      st.global_int_mask_reg[IQS_BIT_LOCAL] && pending == IQS_ZERO |-> host_int_n)
      else $error("local block");
   AST_FIFO_OUT_MODE: assert property (@(posedge mclk) disable iff (sys_rst)
      !st.dir && pending == IQS_ZERO |-> host_int_n)
      else $error("fifo out mode");

   // flag side: set and clear of the sticky bits
   AST_OVF_SET: assert property (@(posedge mclk) disable iff (sys_rst)
      vec_lost |=> st.ovf) else $error("ovf set");
   AST_QFLAG_CLR: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_stat && reg_wdata[0] && !vec_valid && !cmd_vec_valid |=> !st.qflag[0])
      else $error("qflag clear");
   AST_W0_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_stat && !reg_wdata[0] && st.qflag[0] |=> st.qflag[0])
      else $error("zero write");
   AST_CMD_QUEUE: assert property (@(posedge mclk) disable iff (sys_rst)
      cmd_vec_valid |=> st.qflag[IQS_NQ-1]) else $error("cmd queue");

   // register side: read port and configuration writes
   AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_rd && reg_addr == IQS_OFF_STATUS |=> (reg_rdata & ~IQS_STATUS_IMP) == IQS_ZERO)
      else $error("reserved");
   AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == IQS_ZERO) else $error("rdata idle");
   AST_HP_NOMASK: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == IQS_OFF_QINDEX && reg_wdata[3:0] >= 4'(IQS_HPQ)
      |=> st.qmask == $past(st.qmask)) else $error("hp mask");
   AST_DIR: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_wr && reg_addr == IQS_OFF_CTRL |=> local_int_dir_in == $past(reg_wdata[0]))
      else $error("direction");
endmodule
`default_nettype wire

// *** sim/interrupt_queue_status_mask_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module interrupt_queue_status_mask_bench;
   import iqs_pkg::*;
   logic        mclk, sys_rst, reg_wr, reg_rd, vec_valid, cmd_vec_valid;
   logic        vec_lost, fifo_nonempty, raise, local_int_n_n, dir_in, rvalid, host_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, vec_data, rdata;
   logic [2:0]  vec_chan;
   logic [3:0]  rqueue;
   int          num_errors = 0;  // mismatches seen
   int          num_checks = 0;  // comparisons made

   iqs_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .vec_valid(vec_valid), .vec_data(vec_data), .vec_chan(vec_chan),
      .cmd_vec_valid(cmd_vec_valid), .vec_lost(vec_lost), .fifo_nonempty(fifo_nonempty),
      .local_int_n_in(local_int_n_n), .local_int_dir_in(dir_in), .route_valid(rvalid),
      .route_queue(rqueue), .route_data(rdata), .host_int_n(host_n));
   iqs_local_src src_u (.mclk(mclk), .raise(raise), .local_int_n(local_int_n_n));

   // free running 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one cycle write; returns just after the edge that took it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge mclk); reg_wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge mclk); reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // one vector; routed result stands one cycle later
   task automatic send(input logic [2:0] ch, input logic [31:0] v, input logic [3:0] q);
      @(posedge mclk); vec_chan <= ch; vec_data <= v; vec_valid <= 1'b1;
      @(posedge mclk); vec_valid <= 1'b0;
      #1 chk({rvalid, rqueue}, {1'b1, q});
      chk(rdata, v);
   endtask

   task automatic t_reset();
      rdchk(IQS_OFF_GLOBAL_INT_MASK_REG, 32'hFFFF_FFFF);
      rdchk(IQS_OFF_STATUS, 32'h0000_0000);
      rdchk(8'h10, 32'h0000_0000);
      chk(host_n, 1'b1);
      wr(IQS_OFF_PRIO, 32'h0000_8000);
      rdchk(IQS_OFF_PRIO, 32'h0000_8000);
   endtask
   task automatic t_queues();
      wr(IQS_OFF_GLOBAL_INT_MASK_REG, 32'h0000_0000);
      for (int i = 0; i < 8; i++) send(3'(i), 32'h1 << i, 4'(i));
      @(posedge mclk); cmd_vec_valid <= 1'b1;
      @(posedge mclk); cmd_vec_valid <= 1'b0;
      rdchk(IQS_OFF_STATUS, 32'h0000_01FF);
      chk(host_n, 1'b0);
      wr(IQS_OFF_STATUS, 32'h0000_0000);
      rdchk(IQS_OFF_STATUS, 32'h0000_01FF);
      wr(IQS_OFF_STATUS, 32'h0000_01FF);
      rdchk(IQS_OFF_STATUS, 32'h0000_0000);
      chk(host_n, 1'b1);
   endtask
   task automatic t_prio();
      wr(IQS_OFF_QINDEX, 32'h0004_0002);
      send(3'd2, 32'h0000_8000, 4'd7);
      send(3'd2, 32'h0000_0001, 4'd2);
      send(3'd3, 32'h0000_8000, 4'd3);
      wr(IQS_OFF_PRIO, 32'h0000_0001);
      wr(IQS_OFF_QINDEX, 32'h0004_0008);
      wr(IQS_OFF_QINDEX, 32'h0004_0007);
      rdchk(IQS_OFF_QINDEX, 32'h0000_0007);
      send(3'd0, 32'h0000_0001, 4'd0);
      send(3'd7, 32'h0000_0001, 4'd7);
      rdchk(IQS_OFF_STATUS, 32'h0000_008D);
      wr(IQS_OFF_STATUS, 32'h0000_008D);
      rdchk(IQS_OFF_STATUS, 32'h0000_0000);
   endtask
   task automatic t_gate();
      wr(IQS_OFF_GLOBAL_INT_MASK_REG, 32'hFFFF_FFFF);
      send(3'd5, 32'h0000_0004, 4'd5);
      rdchk(IQS_OFF_STATUS, 32'h0000_0020);
      chk(host_n, 1'b1);
      wr(IQS_OFF_GLOBAL_INT_MASK_REG, ~32'h0000_0020);
      chk(host_n, 1'b0);
      wr(IQS_OFF_STATUS, 32'h0000_0020);
      chk(host_n, 1'b1);
   endtask
   task automatic t_ovf();
      wr(IQS_OFF_GLOBAL_INT_MASK_REG, 32'h7FFF_FFFF);
      @(posedge mclk); vec_lost <= 1'b1;
      @(posedge mclk); vec_lost <= 1'b0;
      rdchk(IQS_OFF_STATUS, 32'h8000_0000);
      chk(host_n, 1'b0);
      wr(IQS_OFF_STATUS, 32'h0000_0000);
      rdchk(IQS_OFF_STATUS, 32'h8000_0000);
      wr(IQS_OFF_STATUS, 32'h8000_0000);
      rdchk(IQS_OFF_STATUS, 32'h0000_0000);
      chk(host_n, 1'b1);
   endtask
   task automatic t_local();
      wr(IQS_OFF_GLOBAL_INT_MASK_REG, 32'hFFFC_FFFF);
      @(posedge mclk); fifo_nonempty <= 1'b1;
      rdchk(IQS_OFF_STATUS, 32'h0001_0000);
      chk(host_n, 1'b1);
      wr(IQS_OFF_CTRL, 32'h0000_0001);
      chk({dir_in, host_n}, 2'b10);
      @(posedge mclk); fifo_nonempty <= 1'b0; raise <= 1'b1;
      rdchk(IQS_OFF_STATUS, 32'h0002_0000);
      chk(host_n, 1'b0);
      wr(IQS_OFF_STATUS, 32'h0003_0000);
      rdchk(IQS_OFF_STATUS, 32'h0002_0000);
      wr(IQS_OFF_GLOBAL_INT_MASK_REG, 32'hFFFF_FFFF);
      chk(host_n, 1'b1);
      @(posedge mclk); raise <= 1'b0;
      rdchk(IQS_OFF_STATUS, 32'h0000_0000);
   endtask

   task automatic complete_run();
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog, far beyond the roughly 125 cycles the tests need
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end

   initial begin
      {sys_rst, reg_wr, reg_rd, vec_valid, cmd_vec_valid} = 5'b10000;
      {vec_lost, fifo_nonempty, raise} = 3'b000;
      {reg_addr, reg_wdata, vec_data, vec_chan} = '0;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_queues();
      t_prio();
      t_gate();
      t_ovf();
      t_local();
      complete_run();
   end
endmodule
`default_nettype wire

// *** sim/iqs_local_src.sv ***
`timescale 1ns/100ps
`default_nettype none
// local bus interrupt source, drives the active low local pin
module iqs_local_src (
   input  wire logic mclk,
   input  wire logic raise,
   output logic      local_int_n
);
   // pin follows the request one edge later; idle level is high
   always_ff @(posedge mclk) begin
      local_int_n <= ~raise;
   end
endmodule
`default_nettype wire
